// *** design/dps_top.v ***
/*
 * Drive power state machine: command word interpreter and state report
 * for a servo drive following the usual drive profile.
 * Assumes a plain register port on the core clock and a drive-enable pin
 * that arrives asynchronously and is synchronised here.
 */
// Overview of operation
// - Power-up walks start, init, to switch-on-disabled.
// - Command word writes request state changes; init done, fault events, dwell end and the enable pin also move the state.
// - Report word readable at any time.
// - Internal fault in switched on, operation enabled or quick stop enters reaction, then fault state.
// - Fault left only by reset fault command.
// - Init state disables drive, exits when done.
// - Fatal error on entering disabled state self-resets fault.
// - Only shutdown leaves switch-on-disabled.
// - Ready state: no energy, loops inactive.
// - Ready: switch on, disable voltage, quick stop.
// - Switched on: bridge on, zero command, no target.
// - Switched on: enable, shutdown, disable, quick stop.
// - Operation enabled powers motor, processes targets.
// - Operation enabled: quick stop enters quick stop.
// - Operation enabled: shutdown, disable, enable pin low.
// - Operation enabled: switch on returns switched on.
// - Shutdown 06, switch on 07, enable 0f.
// - Disable bit1 low, quick stop, fault reset edge.
// - Fault reaction dwells 100 us to 2 ms.
// - Report bits: ready, on, enabled, fault, voltage.
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_top
(
    input wire mclk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [`DPS_ADDR_W-1:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire drive_en_in,
    output reg [15:0] rdata_out,
    output reg bridge_en_out,
    output reg loops_run_out,
    output reg zero_cmd_out,
    output reg target_en_out,
    output reg fault_reset_out
);
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg started_reg;
    reg [15:0] state_command_word_reg;
    reg cmd_pulse_reg;
    reg rst_bit_prev_reg;
    reg [15:0] ctrl_reg;
    reg fault_evt_reg;
    reg [15:0] dwell_reg;
    reg auto_reset_reg;
    reg [15:0] state_report_word;
    wire drive_en_sync;
    wire cmd_shutdown;
    wire cmd_switch_on;
    wire cmd_enable_op;
    wire cmd_disable;
    wire cmd_qstop;
    wire cmd_reset_fault;
    wire dwell_done;
    wire [15:0] cw;

    // The drive-enable pin is asynchronous, so it passes two flops first.
    dps_sync2 u_en_sync
    (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .d_in(drive_en_in),
        .q_out(drive_en_sync)
    );

    assign cw = state_command_word_reg;

    // Command decode, valid only in the cycle after a command write.
    assign cmd_disable = cmd_pulse_reg && !cw[7] && !cw[`DPS_CMD_VOLT];
    assign cmd_qstop = cmd_pulse_reg && !cw[7] && cw[`DPS_CMD_VOLT] && !cw[`DPS_CMD_QSTOP];
    assign cmd_shutdown = cmd_pulse_reg && !cw[7] && cw[2] && cw[1] && !cw[0];
    assign cmd_switch_on = cmd_pulse_reg && !cw[7] && !cw[3] && cw[2] && cw[1] && cw[0];
    assign cmd_enable_op = cmd_pulse_reg && !cw[7] && cw[3] && cw[2] && cw[1] && cw[0];
    assign cmd_reset_fault = cmd_pulse_reg && cw[`DPS_CMD_RSTF] && !rst_bit_prev_reg;

    assign dwell_done = (dwell_reg >= (`DPS_FRA_CYC - 1));

    // Register writes: the command word is write-only; the control register
    // carries the init-done and fatal-error levels and a fault event strobe.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_command_word_reg <= `DPS_CMD_RST;
            cmd_pulse_reg <= 1'b0;
            rst_bit_prev_reg <= 1'b0;
            ctrl_reg <= `DPS_CTRL_RST;
            fault_evt_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            cmd_pulse_reg <= 1'b0;
            fault_evt_reg <= 1'b0;
            if (cmd_pulse_reg)
            begin
                // Edge detection of the reset bit compares successive writes.
                rst_bit_prev_reg <= cw[`DPS_CMD_RSTF];
            end
            if (wr_in && addr_in == `DPS_OFF_CMD)
            begin
                state_command_word_reg <= wdata_in;
                cmd_pulse_reg <= 1'b1;
            end
            if (wr_in && addr_in == `DPS_OFF_CTRL)
            begin
                ctrl_reg <= {14'h0000, wdata_in[1:0]};
                fault_evt_reg <= wdata_in[`DPS_CTRL_FAULT];
            end
        end
    end

    // Next-state logic; anything not listed holds the state.
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            `DPS_ST_START:
            begin
                if (!started_reg)
                begin
                    state_next = `DPS_ST_NRDY;
                end
                else if (cmd_reset_fault)
                begin
                    state_next = `DPS_ST_SOD;
                end
            end
            `DPS_ST_NRDY:
            begin
                if (ctrl_reg[`DPS_CTRL_INIT])
                begin
                    state_next = `DPS_ST_SOD;
                end
            end
            `DPS_ST_SOD:
            begin
                if (cmd_shutdown && !ctrl_reg[`DPS_CTRL_FATAL])
                begin
                    state_next = `DPS_ST_RDY;
                end
            end
            `DPS_ST_RDY:
            begin
                if (cmd_disable || cmd_qstop)
                begin
                    state_next = `DPS_ST_SOD;
                end
                else if (cmd_switch_on)
                begin
                    state_next = `DPS_ST_SWON;
                end
            end
            `DPS_ST_SWON:
            begin
                if (cmd_disable || cmd_qstop)
                begin
                    state_next = `DPS_ST_SOD;
                end
                else if (cmd_shutdown)
                begin
                    state_next = `DPS_ST_RDY;
                end
                else if (cmd_enable_op)
                begin
                    state_next = `DPS_ST_OPEN;
                end
            end
            `DPS_ST_OPEN:
            begin
                if (cmd_disable || !drive_en_sync)
                begin
                    state_next = `DPS_ST_SOD;
                end
                else if (cmd_qstop)
                begin
                    state_next = `DPS_ST_QSA;
                end
                else if (cmd_shutdown)
                begin
                    state_next = `DPS_ST_RDY;
                end
                else if (cmd_switch_on)
                begin
                    state_next = `DPS_ST_SWON;
                end
            end
            `DPS_ST_QSA:
            begin
                if (cmd_disable || !drive_en_sync)
                begin
                    state_next = `DPS_ST_SOD;
                end
                else if (cmd_enable_op)
                begin
                    state_next = `DPS_ST_OPEN;
                end
            end
            `DPS_ST_FRA:
            begin
                if (dwell_done)
                begin
                    state_next = `DPS_ST_FAULT;
                end
            end
            default:
            begin
                state_next = state_reg;
            end
        endcase
        // A fault event only counts in a bridge-on state; the registered bridge
        // output lags the state by a cycle and would let a stale event through.
        if (fault_evt_reg && ((state_reg == `DPS_ST_SWON) || (state_reg == `DPS_ST_OPEN) ||
            (state_reg == `DPS_ST_QSA)))
        begin
            state_next = `DPS_ST_FRA;
        end
    end

    // The start and fault states share a code; started_reg tells them apart,
    // which saves a state bit at the cost of one extra flop.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= `DPS_ST_START;
            started_reg <= 1'b0;
            dwell_reg <= 16'h0000;
            auto_reset_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            auto_reset_reg <= 1'b0;
            if (state_reg == `DPS_ST_NRDY)
            begin
                started_reg <= 1'b1;
            end
            if (state_reg == `DPS_ST_FRA)
            begin
                dwell_reg <= dwell_reg + 16'h0001;
            end
            else
            begin
                dwell_reg <= 16'h0000;
            end
            state_reg <= state_next;
            // Entering the disabled state with a fatal error self-issues a reset.
            if (state_next == `DPS_ST_SOD && state_reg != `DPS_ST_SOD && ctrl_reg[`DPS_CTRL_FATAL])
            begin
                auto_reset_reg <= 1'b1;
            end
        end
    end

    // Report word built from the state; fault state needs started_reg.
    always @*
    begin
        state_report_word = 16'h0000;
        case (state_reg)
            `DPS_ST_START:
            begin
                state_report_word[`DPS_RPT_FAULT] = started_reg;
            end
            `DPS_ST_RDY:
            begin
                state_report_word[`DPS_RPT_RDY] = 1'b1;
            end
            `DPS_ST_SWON:
            begin
                state_report_word[`DPS_RPT_RDY] = 1'b1;
                state_report_word[`DPS_RPT_SWON] = 1'b1;
                state_report_word[`DPS_RPT_VOLT] = 1'b1;
            end
            `DPS_ST_OPEN, `DPS_ST_QSA:
            begin
                state_report_word[`DPS_RPT_RDY] = 1'b1;
                state_report_word[`DPS_RPT_SWON] = 1'b1;
                state_report_word[`DPS_RPT_OPEN] = 1'b1;
                state_report_word[`DPS_RPT_VOLT] = 1'b1;
            end
            `DPS_ST_FRA:
            begin
                state_report_word[`DPS_RPT_RDY] = 1'b1;
                state_report_word[`DPS_RPT_SWON] = 1'b1;
                state_report_word[`DPS_RPT_OPEN] = 1'b1;
                state_report_word[`DPS_RPT_FAULT] = 1'b1;
                state_report_word[`DPS_RPT_VOLT] = 1'b1;
            end
            default:
            begin
                state_report_word = 16'h0000;
            end
        endcase
    end

    // Outputs follow the state with one register stage; read data likewise.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out <= 16'h0000;
            bridge_en_out <= 1'b0;
            loops_run_out <= 1'b0;
            zero_cmd_out <= 1'b0;
            target_en_out <= 1'b0;
            fault_reset_out <= 1'b0;
        end
        else if (ce_in)
        begin
            rdata_out <= 16'h0000;
            if (rd_in)
            begin
                case (addr_in)
                    `DPS_OFF_REPORT: rdata_out <= state_report_word;
                    `DPS_OFF_CTRL: rdata_out <= ctrl_reg;
                    `DPS_OFF_STAT: rdata_out <= {13'h0000, state_reg};
                    default: rdata_out <= 16'h0000; // Command word is write-only.
                endcase
            end
            // Init, disabled and ready states keep bridge, loops, zero command and target off.
            bridge_en_out <= (state_reg == `DPS_ST_SWON) || (state_reg == `DPS_ST_OPEN) ||
                             (state_reg == `DPS_ST_QSA) || (state_reg == `DPS_ST_FRA);
            loops_run_out <= (state_reg == `DPS_ST_SWON) || (state_reg == `DPS_ST_OPEN) ||
                             (state_reg == `DPS_ST_QSA) || (state_reg == `DPS_ST_FRA);
            zero_cmd_out <= (state_reg == `DPS_ST_SWON);
            target_en_out <= (state_reg == `DPS_ST_OPEN) || (state_reg == `DPS_ST_FRA);
            fault_reset_out <= auto_reset_reg;
        end
    end
endmodule // dps_top

// *** design/dps_map.vh ***
/*
 * Constants for the drive power state machine: register offsets, command
 * word fields, report word bit positions, state codes and timing counts.
 * Assumes a 200 MHz core clock; included by bare name from design files.
 */
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// Register offsets on the plain register port.
`define DPS_ADDR_W 4
`define DPS_OFF_CMD 4'h0
`define DPS_OFF_REPORT 4'h1
`define DPS_OFF_CTRL 4'h2
`define DPS_OFF_STAT 4'h3

// Command word bit positions.
`define DPS_CMD_SWON 0
`define DPS_CMD_VOLT 1
`define DPS_CMD_QSTOP 2
`define DPS_CMD_ENOP 3
`define DPS_CMD_RSTF 7

// Report word bit positions.
`define DPS_RPT_RDY 0
`define DPS_RPT_SWON 1
`define DPS_RPT_OPEN 2
`define DPS_RPT_FAULT 3
`define DPS_RPT_VOLT 4

// Control register bits (init done, fatal error, fault event).
`define DPS_CTRL_INIT 0
`define DPS_CTRL_FATAL 1
`define DPS_CTRL_FAULT 2

// Reset values.
`define DPS_CMD_RST 16'h0000
`define DPS_CTRL_RST 16'h0000

// State codes.
`define DPS_ST_START 3'h0
`define DPS_ST_NRDY 3'h1
`define DPS_ST_SOD 3'h2
`define DPS_ST_RDY 3'h3
`define DPS_ST_SWON 3'h4
`define DPS_ST_OPEN 3'h5
`define DPS_ST_QSA 3'h6
`define DPS_ST_FRA 3'h7
`define DPS_ST_FAULT 3'h0

// Fault reaction dwell: between 100 us and 2 ms; 100 us picked.
`define DPS_CLK_MHZ 200
`define DPS_FRA_US 100
`define DPS_FRA_CYC (`DPS_FRA_US * `DPS_CLK_MHZ)

`endif

// *** design/dps_sync2.v ***
/*
 * Two-stage synchroniser for one level from outside the clock domain.
 * Assumes the input is a slow level; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module dps_sync2
(
    input wire mclk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire d_in,
    output wire q_out
);
    reg meta_reg;
    reg q_reg;

    // Plain double flop, frozen with the clock enable like all other state.
    always @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= 1'b0;
            q_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            meta_reg <= d_in;
            q_reg <= meta_reg;
        end
    end

    assign q_out = q_reg;
endmodule // dps_sync2

// *** tb/dps_props.sv ***
/*
 * Port checker for the drive power state machine.
 * Assumes it is bound to dps_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "dps_map.vh"
module dps_props
(
    input wire mclk_in,
    input wire rst_n_in,
    input wire ce_in,
    input wire [`DPS_ADDR_W-1:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire drive_en_in,
    input wire [15:0] rdata_out,
    input wire bridge_en_out,
    input wire loops_run_out,
    input wire zero_cmd_out,
    input wire target_en_out,
    input wire fault_reset_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // Read data must not linger, or a host could mistake stale data for an answer.
    rdata_idle_a:
    assert property (!rd_in |=> rdata_out == 16'h0000) else $error("read data outside read slot");
    cmd_unread_a:
    assert property (rd_in && addr_in == `DPS_OFF_CMD |=> rdata_out == 16'h0000) else $error("command word readable");
    frs_pulse_a:
    assert property (fault_reset_out |=> !fault_reset_out) else $error("fault reset longer than one cycle");
    frs_dark_a:
    assert property (fault_reset_out |-> !bridge_en_out) else $error("fault reset with bridge on");
    target_power_a:
    assert property (target_en_out |-> bridge_en_out && loops_run_out && !zero_cmd_out) else $error("target bad");
    zero_power_a:
    assert property (zero_cmd_out |-> bridge_en_out && loops_run_out && !target_en_out) else $error("zero bad");
    dark_idle_a:
    assert property (!bridge_en_out |-> !loops_run_out && !zero_cmd_out && !target_en_out) else $error("dark bad");
    bridge_cause_a:
    assert property ($rose(bridge_en_out) |-> $past(wr_in, 2) || $past(wr_in, 3) || $past(wr_in, 4))
        else $error("bridge rose without a write");
    enable_drop_a:
    assert property ($fell(drive_en_in) && target_en_out |-> ##[1:8] !target_en_out)
        else $error("drive enable drop ignored");
    cover property ($rose(target_en_out));
    cover property ($rose(fault_reset_out));
    cover property ($fell(bridge_en_out));
endmodule // dps_props

bind dps_top dps_props props_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .drive_en_in(drive_en_in), .rdata_out(rdata_out),
    .bridge_en_out(bridge_en_out), .loops_run_out(loops_run_out), .zero_cmd_out(zero_cmd_out),
    .target_en_out(target_en_out), .fault_reset_out(fault_reset_out));

// *** tb/dps_host_model.sv ***
/*
 * Network host model: master of the plain register port.
 * Assumes read data arrive in the cycle after the read strobe.
 */
`timescale 1ns/1ps
module dps_host_model
(
    input wire mclk_in,
    input wire [15:0] rdata_in,
    output reg [3:0] addr_out,
    output reg [15:0] wdata_out,
    output reg wr_out,
    output reg rd_out
);
    // Idle bus at time zero.
    initial
    begin
        addr_out = 4'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // Released lines carry the inverse, so a slave cannot lean on stale values.
    task wr_reg(input [3:0] a, input [15:0] v);
    begin
        @(posedge mclk_in);
        addr_out <= a;
        wdata_out <= v;
        wr_out <= 1'b1;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~v;
    end
    endtask

    // Read data are taken inside the one cycle in which they stand.
    task rd_reg(input [3:0] a, output [15:0] v);
    begin
        @(posedge mclk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge mclk_in);
        v = rdata_in;
    end
    endtask
endmodule // dps_host_model

// *** tb/tb.sv ***
/*
 * Self-checking bench for the drive power state machine.
 * Assumes the host model drives the register port; ce drops low only around one command write.
 */
`timescale 1ns/1ps
`include "dps_map.vh"
module tb;
    reg mclk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg ce_in = 1'b1;
    reg drive_en_in = 1'b1;
    wire [3:0] addr;
    wire [15:0] wdata;
    wire [15:0] rdata;
    wire wr;
    wire rd;
    wire bridge;
    wire loops;
    wire zero;
    wire target;
    wire frs;
    integer bad_count = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer frs_seen = 0;
    reg [15:0] d;

    always #2.5 mclk_in = ~mclk_in;

    dps_host_model host_u (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .wr_out(wr), .rd_out(rd));
    dps_top dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .drive_en_in(drive_en_in), .rdata_out(rdata), .bridge_en_out(bridge),
        .loops_run_out(loops), .zero_cmd_out(zero), .target_en_out(target), .fault_reset_out(frs));

    task final_report;
    begin
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // Cycle watchdog; the fault dwell alone takes some 20000 cycles.
    always @(posedge mclk_in)
    begin
        cyc = cyc + 1;
        if (frs === 1'b1)
            frs_seen = frs_seen + 1;
        if (cyc == 60000)
        begin
            bad_count = bad_count + 1;
            final_report;
        end
    end

    task chk(input [8*8:1] nm, input [15:0] e, input [15:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task rdc(input [3:0] a, input [15:0] e, input [8*8:1] nm);
    begin
        host_u.rd_reg(a, d);
        chk(nm, e, d);
    end
    endtask

    function [15:0] rpt(input [2:0] s);
        rpt = (s == 3'h3) ? 16'h0001 : (s == 3'h4) ? 16'h0013 : (s == 3'h5) ? 16'h0017 :
            (s == 3'h0) ? 16'h0008 : 16'h0000;
    endfunction

    function [15:0] outs(input [2:0] s);
        outs = (s == 3'h4) ? 16'h000e : (s == 3'h5) ? 16'h000d : 16'h0000;
    endfunction

    // Write one command, let it settle, then check state, and report and outputs except in states 1, 6 and 7.
    task step(input [7:0] c, input [2:0] s);
    begin
        host_u.wr_reg(`DPS_OFF_CMD, {8'h00, c});
        repeat (4) @(posedge mclk_in);
        rdc(`DPS_OFF_STAT, {13'h0000, s}, "state");
        if (s != 3'h1 && s < 3'h6)
        begin
            rdc(`DPS_OFF_REPORT, rpt(s), "report");
            chk("outputs", outs(s), {12'h000, bridge, loops, zero, target});
        end
    end
    endtask

    initial
    begin
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        #1;
        chk("outputs", 16'h0000, {12'h000, bridge, loops, zero, target});
        step(8'h06, 3'h1);
        host_u.wr_reg(`DPS_OFF_CTRL, 16'h0001);
        repeat (3) @(posedge mclk_in);
        rdc(`DPS_OFF_STAT, 16'h0002, "state");
        chk("frs", 16'h0000, frs_seen[15:0]);
        step(8'h07, 3'h2);
        step(8'h0f, 3'h2);
        step(8'h02, 3'h2);
        step(8'h06, 3'h3);
        step(8'h00, 3'h2);
        step(8'h06, 3'h3);
        step(8'h02, 3'h2);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h00, 3'h2);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h02, 3'h2);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h0f, 3'h5);
        step(8'h07, 3'h4);
        step(8'h0f, 3'h5);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h0f, 3'h5);
        step(8'h00, 3'h2);
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h0f, 3'h5);
        step(8'h02, 3'h6);
        step(8'h0f, 3'h5);
        drive_en_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rdc(`DPS_OFF_STAT, 16'h0002, "state");
        drive_en_in <= 1'b1;
        step(8'h06, 3'h3);
        step(8'h07, 3'h4);
        step(8'h0f, 3'h5);
        host_u.wr_reg(`DPS_OFF_CTRL, 16'h0005);
        repeat (19990) @(posedge mclk_in);
        rdc(`DPS_OFF_STAT, 16'h0007, "state");
        repeat (40) @(posedge mclk_in);
        rdc(`DPS_OFF_STAT, 16'h0000, "state");
        step(8'h06, 3'h0);
        host_u.wr_reg(`DPS_OFF_CTRL, 16'h0003);
        step(8'h80, 3'h2);
        chk("frs", 16'h0001, frs_seen[15:0]);
        step(8'h06, 3'h2);
        host_u.wr_reg(`DPS_OFF_CTRL, 16'h0001);
        step(8'h06, 3'h3);
        ce_in <= 1'b0;
        host_u.wr_reg(`DPS_OFF_CMD, 16'h0000);
        ce_in <= 1'b1;
        rdc(`DPS_OFF_STAT, 16'h0003, "state");
        rdc(`DPS_OFF_CMD, 16'h0000, "cmd");
        rdc(4'h7, 16'h0000, "unmapped");
        final_report;
    end
endmodule // tb
